// ### common/cie_pkg.sv
package cie_pkg;

   localparam int REG_W   = 8;
   localparam int ADDR_W  = 3;
   localparam int LOC_N   = 3;
   localparam int STS_N   = 3;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_PFA  = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_PFB  = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_PEA  = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_PEB  = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_STS  = 3'h5;
   localparam logic [ADDR_W-1:0] ADDR_MSK  = 3'h6;

   localparam int CTRL_GLOBAL_EN_BIT = 7;
   localparam int CTRL_GROUP_EN_BIT  = 6;
   localparam int CTRL_EN_LSB   = 3;
   localparam int CTRL_FLAG_LSB = 0;

   localparam int STS_ENTRY  = 0;
   localparam int STS_RETURN = 1;
   localparam int STS_WAKE   = 2;

   localparam logic [REG_W-1:0] REG_RST   = 8'h00;
   localparam logic [LOC_N-1:0] LOC_RST   = 3'h0;
   localparam logic [STS_N-1:0] STS_RST   = 3'h0;
   localparam logic [15:0]      IRQ_VECTOR = 16'h0004;

   typedef enum logic [1:0]
   {
      CIE_SEQ_IDLE  = 2'b00,
      CIE_SEQ_FLUSH = 2'b01,
      CIE_SEQ_PUSH  = 2'b10,
      CIE_SEQ_VECT  = 2'b11
   } cie_seq_state_type;

endpackage

// ### common/cie_seq_if.sv
`timescale 1ns/1ns
interface cie_seq_if;
   logic irq_req;
   logic return_from_irq_instruction;
   logic fetch_flush;
   logic clr_global_en;
   logic stack_push;
   logic ctx_save;
   logic pc_load;
   logic stack_pop;
   logic ctx_restore;
   logic set_global_en;

   modport ctl
   (
      output irq_req,
      output return_from_irq_instruction,
      input  fetch_flush,
      input  clr_global_en,
      input  stack_push,
      input  ctx_save,
      input  pc_load,
      input  stack_pop,
      input  ctx_restore,
      input  set_global_en
   );

   modport seq
   (
      input  irq_req,
      input  return_from_irq_instruction,
      output fetch_flush,
      output clr_global_en,
      output stack_push,
      output ctx_save,
      output pc_load,
      output stack_pop,
      output ctx_restore,
      output set_global_en
   );
endinterface

// ### rtl/cie_entry_seq.sv
`timescale 1ns/1ns
module cie_entry_seq
(
   input  wire logic clk,
   input  wire logic reset_n,
   cie_seq_if.seq    seq
);
   import cie_pkg::*;

   typedef struct packed
   {
      cie_seq_state_type state;
   } cie_seq_reg_type;

   cie_seq_reg_type seq_ff;
   cie_seq_reg_type nxt_seq;

   always_comb
   begin
      nxt_seq         = seq_ff;
      seq.fetch_flush = 1'b0;
      seq.clr_global_en = 1'b0;
      seq.stack_push  = 1'b0;
      seq.ctx_save    = 1'b0;
      seq.pc_load     = 1'b0;
      seq.stack_pop   = 1'b0;
      seq.ctx_restore = 1'b0;
      seq.set_global_en = 1'b0;
      case (seq_ff.state)
         CIE_SEQ_IDLE:
         begin
            if (seq.irq_req)
            begin
               nxt_seq.state = CIE_SEQ_FLUSH;
            end
            else if (seq.return_from_irq_instruction)
            begin
               seq.stack_pop   = 1'b1;
               seq.ctx_restore = 1'b1;
               seq.set_global_en = 1'b1;
            end
         end
         CIE_SEQ_FLUSH:
         begin
            seq.fetch_flush = 1'b1;
            seq.clr_global_en = 1'b1;
            nxt_seq.state   = CIE_SEQ_PUSH;
         end
         CIE_SEQ_PUSH:
         begin
            seq.stack_push = 1'b1;
            seq.ctx_save   = 1'b1;
            nxt_seq.state  = CIE_SEQ_VECT;
         end
         CIE_SEQ_VECT:
         begin
            // Vector fetch starts the cycle after; keeps entry within the latency budget
            seq.pc_load   = 1'b1;
            nxt_seq.state = CIE_SEQ_IDLE;
         end
         default:
         begin
            nxt_seq.state = CIE_SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         seq_ff.state <= CIE_SEQ_IDLE;
      end
      else
      begin
         seq_ff <= nxt_seq;
      end
   end
endmodule // cie_entry_seq

// ### rtl/cie_irq_entry_exit.sv
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// Behaviour
// - Any reset leaves the global enable clear so no interrupt is taken until software sets it.
// - A vector jump needs the global enable and the event's own enable both set.
// - Peripheral-group events additionally need the peripheral group enable set.
// - Every event is held in its own flag bit in the control or one of two peripheral flag regs.
// - A flag is set by its event whatever the state of any enable bit.
// - Entry flushes the prefetch, clears global enable, pushes the PC, saves context, loads 0004h.
// - While global enable is clear, new events set flags but cause no redirection.
// - Return pops the address, restores the saved context and sets global enable.
// - Pending enabled flags raised while global enable was clear are taken once it is set.
// - Enabled sources can wake the processor out of Sleep.
// - Event to first vector instruction takes a small fixed number of cycles.
module cie_irq_entry_exit
#(
   parameter int PC_W  = 15,
   parameter int CTX_W = 40
)
(
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic [cie_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [cie_pkg::REG_W-1:0]  reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output      logic [cie_pkg::REG_W-1:0]  reg_rdata,
   input  wire logic [cie_pkg::LOC_N-1:0]  local_event,
   input  wire logic [cie_pkg::REG_W-1:0]  periph_event_a,
   input  wire logic [cie_pkg::REG_W-1:0]  periph_event_b,
   input  wire logic                       return_from_irq_instruction,
   input  wire logic                       sleep_active,
   input  wire logic [PC_W-1:0]            core_pc,
   input  wire logic [CTX_W-1:0]           core_ctx,
   output      logic                       fetch_flush,
   output      logic                       stack_push,
   output      logic [PC_W-1:0]            stack_push_pc,
   output      logic                       ctx_save,
   output      logic                       pc_load,
   output      logic [PC_W-1:0]            pc_load_value,
   output      logic                       stack_pop,
   output      logic                       ctx_restore,
   output      logic [CTX_W-1:0]           ctx_restore_value,
   output      logic                       wake_request,
   output      logic                       global_irq_enable,
   output      logic                       irq
);
   import cie_pkg::*;

   localparam logic [PC_W-1:0] VECTOR_PC = IRQ_VECTOR[PC_W-1:0];

   typedef struct packed
   {
      logic                 global_en;
      logic                 group_en;
      logic [LOC_N-1:0]     loc_en;
      logic [LOC_N-1:0]     loc_flag;
      logic [REG_W-1:0]     flag_a;
      logic [REG_W-1:0]     flag_b;
      logic [REG_W-1:0]     en_a;
      logic [REG_W-1:0]     en_b;
      logic [STS_N-1:0]     sts;
      logic [STS_N-1:0]     msk;
      logic [REG_W-1:0]     rdata;
      logic [PC_W-1:0]      push_pc;
      logic [PC_W-1:0]      load_pc;
      logic [CTX_W-1:0]     shadow;
   } cie_state_type;

   cie_state_type state_ff;
   cie_state_type nxt_state;

   cie_seq_if seq_bus ();

   logic                 wr_ctrl;
   logic                 wr_pfa;
   logic                 wr_pfb;
   logic                 wr_pea;
   logic                 wr_peb;
   logic                 wr_sts;
   logic                 wr_msk;
   logic                 loc_pend;
   logic                 grp_pend;
   logic                 any_pend;
   logic [REG_W-1:0]     ctrl_view;
   logic [STS_N-1:0]     sts_event;

   function automatic logic pending_any
   (
      input logic [REG_W-1:0] flags,
      input logic [REG_W-1:0] enables
   );
      pending_any = |(flags & enables);
   endfunction

   // Event set is OR-ed after the write so a clearing write never loses a new event
   function automatic logic [REG_W-1:0] flag_next
   (
      input logic [REG_W-1:0] old_val,
      input logic             wr_hit,
      input logic [REG_W-1:0] wr_val,
      input logic [REG_W-1:0] events
   );
      flag_next = (wr_hit ? wr_val : old_val) | events;
   endfunction

   function automatic logic [REG_W-1:0] widen_loc
   (
      input logic [LOC_N-1:0] v
   );
      widen_loc = {{(REG_W-LOC_N){1'b0}}, v};
   endfunction

   assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
   assign wr_pfa  = reg_wr && (reg_addr == ADDR_PFA);
   assign wr_pfb  = reg_wr && (reg_addr == ADDR_PFB);
   assign wr_pea  = reg_wr && (reg_addr == ADDR_PEA);
   assign wr_peb  = reg_wr && (reg_addr == ADDR_PEB);
   assign wr_sts  = reg_wr && (reg_addr == ADDR_STS);
   assign wr_msk  = reg_wr && (reg_addr == ADDR_MSK);

   // Pending terms ignore the global enable so Sleep wake still works with it clear
   assign loc_pend = pending_any(widen_loc(state_ff.loc_flag), widen_loc(state_ff.loc_en));
   assign grp_pend = state_ff.group_en &&
                     (pending_any(state_ff.flag_a, state_ff.en_a) ||
                      pending_any(state_ff.flag_b, state_ff.en_b));
   assign any_pend = loc_pend || grp_pend;

   // Request held low while global enable is clear; flags wait, taken once it is set
   assign seq_bus.irq_req = state_ff.global_en && any_pend;
   assign seq_bus.return_from_irq_instruction = return_from_irq_instruction;

   cie_entry_seq i_cie_entry_seq
   (
      .clk     (clk),
      .reset_n (reset_n),
      .seq     (seq_bus.seq)
   );

   assign wake_request = sleep_active && any_pend;

   always_comb
   begin
      ctrl_view = REG_RST;
      ctrl_view[CTRL_GLOBAL_EN_BIT]                = state_ff.global_en;
      ctrl_view[CTRL_GROUP_EN_BIT]                 = state_ff.group_en;
      ctrl_view[CTRL_EN_LSB +: LOC_N]              = state_ff.loc_en;
      ctrl_view[CTRL_FLAG_LSB +: LOC_N]            = state_ff.loc_flag;
   end

   always_comb
   begin
      sts_event            = STS_RST;
      sts_event[STS_ENTRY]  = seq_bus.pc_load;
      sts_event[STS_RETURN] = seq_bus.stack_pop;
      sts_event[STS_WAKE]   = wake_request;
   end

   always_comb
   begin
      nxt_state = state_ff;

      if (wr_ctrl)
      begin
         nxt_state.global_en = reg_wdata[CTRL_GLOBAL_EN_BIT];
         nxt_state.group_en  = reg_wdata[CTRL_GROUP_EN_BIT];
         nxt_state.loc_en = reg_wdata[CTRL_EN_LSB +: LOC_N];
      end
      // Hardware entry and exit override a software write in the same cycle
      if (seq_bus.clr_global_en)
      begin
         nxt_state.global_en = 1'b0;
      end
      else if (seq_bus.set_global_en)
      begin
         nxt_state.global_en = 1'b1;
      end

      nxt_state.loc_flag = LOC_RST |
                           ((wr_ctrl ? reg_wdata[CTRL_FLAG_LSB +: LOC_N] : state_ff.loc_flag)
                            | local_event);
      nxt_state.flag_a = flag_next(state_ff.flag_a, wr_pfa,
                                   reg_wdata, periph_event_a);
      nxt_state.flag_b = flag_next(state_ff.flag_b, wr_pfb,
                                   reg_wdata, periph_event_b);

      if (wr_pea)
      begin
         nxt_state.en_a = reg_wdata;
      end
      if (wr_peb)
      begin
         nxt_state.en_b = reg_wdata;
      end
      if (wr_msk)
      begin
         nxt_state.msk = reg_wdata[STS_N-1:0];
      end
      nxt_state.sts = ((wr_sts ? (state_ff.sts & ~reg_wdata[STS_N-1:0]) : state_ff.sts)
                       | sts_event);

      if (seq_bus.fetch_flush)
      begin
         nxt_state.push_pc = core_pc;
      end
      if (seq_bus.ctx_save)
      begin
         nxt_state.shadow  = core_ctx;
         nxt_state.load_pc = VECTOR_PC;
      end

      nxt_state.rdata = REG_RST;
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_CTRL: nxt_state.rdata = ctrl_view;
            ADDR_PFA:  nxt_state.rdata = state_ff.flag_a;
            ADDR_PFB:  nxt_state.rdata = state_ff.flag_b;
            ADDR_PEA:  nxt_state.rdata = state_ff.en_a;
            ADDR_PEB:  nxt_state.rdata = state_ff.en_b;
            ADDR_STS:  nxt_state.rdata = {{(REG_W-STS_N){1'b0}}, state_ff.sts};
            ADDR_MSK:  nxt_state.rdata = {{(REG_W-STS_N){1'b0}}, state_ff.msk};
            default:   nxt_state.rdata = REG_RST;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff.global_en <= 1'b0;
         state_ff.group_en  <= 1'b0;
         state_ff.loc_en   <= LOC_RST;
         state_ff.loc_flag <= LOC_RST;
         state_ff.flag_a   <= REG_RST;
         state_ff.flag_b   <= REG_RST;
         state_ff.en_a     <= REG_RST;
         state_ff.en_b     <= REG_RST;
         state_ff.sts      <= STS_RST;
         state_ff.msk      <= STS_RST;
         state_ff.rdata    <= REG_RST;
         state_ff.push_pc  <= '0;
         state_ff.load_pc  <= '0;
         state_ff.shadow   <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign reg_rdata         = state_ff.rdata;
   assign fetch_flush       = seq_bus.fetch_flush;
   assign stack_push        = seq_bus.stack_push;
   assign stack_push_pc     = state_ff.push_pc;
   assign ctx_save          = seq_bus.ctx_save;
   assign pc_load           = seq_bus.pc_load;
   assign pc_load_value     = state_ff.load_pc;
   assign stack_pop         = seq_bus.stack_pop;
   assign ctx_restore       = seq_bus.ctx_restore;
   assign ctx_restore_value = state_ff.shadow;
   assign global_irq_enable = state_ff.global_en;
   assign irq               = |(state_ff.sts & state_ff.msk);
endmodule // cie_irq_entry_exit

// ### dv/cie_irq_entry_exit_assertions.sv
`timescale 1ns/1ns
module cie_irq_entry_exit_checker
#(
   parameter int PC_W  = 15,
   parameter int CTX_W = 40
)
(
   input wire logic             clk,
   input wire logic             reset_n,
   input wire logic             sleep_active,
   input wire logic [PC_W-1:0]  core_pc,
   input wire logic [CTX_W-1:0] core_ctx,
   input wire logic             fetch_flush,
   input wire logic             stack_push,
   input wire logic [PC_W-1:0]  stack_push_pc,
   input wire logic             ctx_save,
   input wire logic             pc_load,
   input wire logic [PC_W-1:0]  pc_load_value,
   input wire logic             stack_pop,
   input wire logic             ctx_restore,
   input wire logic [CTX_W-1:0] ctx_restore_value,
   input wire logic             wake_request,
   input wire logic             global_irq_enable
);
   import cie_pkg::*;
   logic [CTX_W-1:0] shadow_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Own copy of the saved context, so a shadow that never loads is caught
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         shadow_ff <= '0;
      else if (stack_push)
         shadow_ff <= core_ctx;
   end
   reset_global_en_a: assert property ($rose(reset_n) |-> !global_irq_enable)
      else $error("global enable set after reset");
   entry_gate_a: assert property (fetch_flush |-> global_irq_enable)
      else $error("entry without global enable");
   entry_order_a: assert property (fetch_flush |=> stack_push && ctx_save ##1 pc_load)
      else $error("entry steps out of order");
   vector_a: assert property (pc_load |-> pc_load_value == IRQ_VECTOR[PC_W-1:0])
      else $error("wrong vector");
   global_en_drop_a: assert property (fetch_flush |=> !global_irq_enable [*3])
      else $error("global enable not cleared on entry");
   push_pc_a: assert property (stack_push |-> stack_push_pc == $past(core_pc))
      else $error("pushed address wrong");
   return_a: assert property (stack_pop |-> ctx_restore ##1 global_irq_enable)
      else $error("return did not restore");
   restore_a: assert property (stack_pop |-> ctx_restore_value == shadow_ff)
      else $error("restored context wrong");
   wake_a: assert property (wake_request |-> sleep_active)
      else $error("wake outside sleep");
   cover property (pc_load);
   cover property (stack_pop);
   cover property (wake_request);
endmodule // cie_irq_entry_exit_checker

bind cie_irq_entry_exit cie_irq_entry_exit_checker
#(
   .PC_W  (PC_W),
   .CTX_W (CTX_W)
)
i_cie_irq_entry_exit_checker
(
   .clk               (clk),
   .reset_n           (reset_n),
   .sleep_active      (sleep_active),
   .core_pc           (core_pc),
   .core_ctx          (core_ctx),
   .fetch_flush       (fetch_flush),
   .stack_push        (stack_push),
   .stack_push_pc     (stack_push_pc),
   .ctx_save          (ctx_save),
   .pc_load           (pc_load),
   .pc_load_value     (pc_load_value),
   .stack_pop         (stack_pop),
   .ctx_restore       (ctx_restore),
   .ctx_restore_value (ctx_restore_value),
   .wake_request      (wake_request),
   .global_irq_enable (global_irq_enable)
);

// ### dv/cie_core_model.sv
`timescale 1ns/1ns
module cie_core_model
#(
   parameter int PC_W  = 15,
   parameter int CTX_W = 40,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             stack_push,
   input  wire logic [PC_W-1:0]  stack_push_pc,
   input  wire logic             pc_load,
   input  wire logic [PC_W-1:0]  pc_load_value,
   input  wire logic             stack_pop,
   output      logic [PC_W-1:0]  core_pc,
   output      logic [CTX_W-1:0] core_ctx,
   output      int               depth
);
   logic [PC_W-1:0] stack_ff [DEPTH];
   // Context changes every cycle, so a late sample shows up as a mismatch
   assign core_ctx = CTX_W'({core_pc, ~core_pc});
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         core_pc <= '0;
         depth   <= 0;
      end
      else
      begin
         core_pc <= core_pc + 1'b1;
         if (stack_push)
         begin
            stack_ff[depth] <= stack_push_pc;
            depth           <= depth + 1;
         end
         if (pc_load)
            core_pc <= pc_load_value;
         if (stack_pop)
         begin
            core_pc <= stack_ff[depth-1];
            depth   <= depth - 1;
         end
      end
   end
endmodule // cie_core_model

// ### dv/tb_cpu_interrupt_entry_exit.sv
`timescale 1ns/1ns
module tb_cpu_interrupt_entry_exit;
   import cie_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [2:0]  reg_addr = '0;
   logic [7:0]  reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic [2:0]  local_event = '0;
   logic [7:0]  pev_a = '0;
   logic [7:0]  pev_b = '0;
   logic        ret = 1'b0;
   logic        sleep = 1'b0;
   logic [14:0] core_pc, push_pc, load_val;
   logic [39:0] core_ctx;
   logic        fetch_flush, stack_push, pc_load, stack_pop, wake_request;
   logic        global_irq_enable, irq;
   int          depth;
   int          fail_count = 0;
   int          total_checks = 0;

   always #2 clk = ~clk;

   cie_irq_entry_exit i_cie_irq_entry_exit
   (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_event(local_event),
      .periph_event_a(pev_a), .periph_event_b(pev_b), .return_from_irq_instruction(ret),
      .sleep_active(sleep), .core_pc(core_pc), .core_ctx(core_ctx),
      .fetch_flush(fetch_flush), .stack_push(stack_push), .stack_push_pc(push_pc),
      .ctx_save(), .pc_load(pc_load), .pc_load_value(load_val), .stack_pop(stack_pop),
      .ctx_restore(), .ctx_restore_value(), .wake_request(wake_request),
      .global_irq_enable(global_irq_enable), .irq(irq)
   );

   cie_core_model i_cie_core_model
   (
      .clk(clk), .reset_n(reset_n), .stack_push(stack_push), .stack_push_pc(push_pc),
      .pc_load(pc_load), .pc_load_value(load_val), .stack_pop(stack_pop),
      .core_pc(core_pc), .core_ctx(core_ctx), .depth(depth)
   );

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // wr, rd and ev each end at a rising edge; the idle cycle avoids re-driving strobes
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", exp, reg_rdata);
      @(posedge clk);
   endtask

   task automatic ev(input logic [2:0] l, input logic [7:0] a, input logic [7:0] b);
      local_event <= l;
      pev_a       <= a;
      pev_b       <= b;
      @(posedge clk);
      local_event <= '0;
      pev_a       <= '0;
      pev_b       <= '0;
      @(posedge clk);
   endtask

   task automatic flush_seen(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (12)
      begin
         #1 seen |= fetch_flush;
         @(posedge clk);
      end
      chk("fetch_flush", exp, seen);
   endtask

   task automatic leave_isr;
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      #1 chk("global_irq_enable", 1, global_irq_enable);
      chk("depth", 0, depth);
      @(posedge clk);
   endtask

   task automatic t_reset;
      chk("global_irq_enable", 0, global_irq_enable);
      rd(ADDR_CTRL, 8'h00);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
      rd(ADDR_CTRL, 8'h00);
   endtask

   task automatic t_flags;
      ev(3'h5, 8'h81, 8'h40);
      rd(ADDR_CTRL, 8'h05);
      rd(ADDR_PFA, 8'h81);
      rd(ADDR_PFB, 8'h40);
      wr(ADDR_CTRL, 8'h85);
      flush_seen(1'b0);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_PFA, 8'h00);
      wr(ADDR_PFB, 8'h00);
   endtask

   task automatic t_group;
      wr(ADDR_PEA, 8'h04);
      ev(3'h0, 8'h04, 8'h00);
      wr(ADDR_CTRL, 8'h80);
      flush_seen(1'b0);
      wr(ADDR_CTRL, 8'hc0);
      flush_seen(1'b1);
      wr(ADDR_PFA, 8'h00);
      leave_isr();
   endtask

   task automatic t_entry;
      wr(ADDR_CTRL, 8'hc8);
      local_event <= 3'h1;
      @(posedge clk);
      local_event <= 3'h0;
      repeat (3) @(posedge clk);
      #1 chk("pc_load", 1, pc_load);
      @(posedge clk);
      #1 chk("core_pc", 16'h0004, core_pc);
      chk("depth", 1, depth);
      chk("global_irq_enable", 0, global_irq_enable);
      ev(3'h0, 8'h04, 8'h00);
      flush_seen(1'b0);
      rd(ADDR_PFA, 8'h04);
      // Flag is still set from entry; the event lands only on the clearing write's edge
      reg_addr    <= ADDR_CTRL;
      reg_wdata   <= 8'h48;
      reg_wr      <= 1'b1;
      local_event <= 3'h1;
      @(posedge clk);
      reg_wr      <= 1'b0;
      local_event <= 3'h0;
      @(posedge clk);
      rd(ADDR_CTRL, 8'h49);
      wr(ADDR_CTRL, 8'h48);
      wr(ADDR_PFA, 8'h00);
      leave_isr();
      flush_seen(1'b0);
   endtask

   task automatic t_wake;
      wr(ADDR_CTRL, 8'h08);
      ev(3'h1, 8'h00, 8'h00);
      sleep <= 1'b1;
      @(posedge clk);
      #1 chk("wake_request", 1, wake_request);
      @(posedge clk);
      sleep <= 1'b0;
      // Wake status is set here but still masked off
      #1 chk("irq", 0, irq);
      @(posedge clk);
      wr(ADDR_MSK, 8'h04);
      #1 chk("irq", 1, irq);
      @(posedge clk);
      rd(ADDR_STS, 8'h07);
      wr(ADDR_STS, 8'h07);
      rd(ADDR_STS, 8'h00);
      #1 chk("irq", 0, irq);
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_flags();
      t_group();
      t_entry();
      t_wake();
      stop_test();
   end

   initial
   begin
      #20000;
      fail_count++;
      stop_test();
   end
endmodule // tb_cpu_interrupt_entry_exit
